// File: hw/fwp_pkg.sv
/*
  Shared constants and types for the flash protection / erase-window
  controller: register offsets, field positions, op codes, timing.
  Assumes a 50 MHz system clock and an 8-bit flash data bus.
*/
`default_nettype none

package fwp_pkg;

  // system clock period
  localparam int CLK_NS = 20;

  // software register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // field positions
  localparam int CTRL_GO_BIT = 8;
  localparam int MODE_TMP_UNPROT_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REJECT_BIT = 1;
  localparam int ST_TOGGLE_BIT = 2;
  localparam int ST_FIRST_HIGH_BIT = 3;
  localparam int DQ_WINDOW_BIT = 3;
  localparam int DQ_TOGGLE_BIT = 6;

  // reset values
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [7:0] RST_WDATA = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin timing in ns, and derived cycle counts (least times round up)
  localparam int SETUP_NS = 20;
  localparam int ACCESS_NS = 70;
  localparam int HOLD_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    FWP_OP_READ,
    FWP_OP_WRITE,
    FWP_OP_PROTECT,
    FWP_OP_VERIFY,
    FWP_OP_UNPROT,
    FWP_OP_TOGGLE,
    FWP_OP_ERASE_ADD
  } fwp_op_t;

  typedef enum logic [1:0] {
    FWP_IDLE,
    FWP_SETUP,
    FWP_STROBE,
    FWP_HOLD
  } fwp_state_t;

endpackage

`default_nettype wire

// File: hw/fwp_sync.sv
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes each bit settles independently; only the second stage is read.
*/
`default_nettype none

module fwp_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] din, // raw pin level
  output logic [W-1:0] dout // synchronised level
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

`default_nettype wire

// File: hw/fwp_ctrl.sv
/*
  Host-side controller for a parallel flash: drives strobes, address,
  data and high-voltage qualifiers; runs read, write, protect, verify,
  chip unprotect, toggle check and guarded erase-add sequences.
  Assumes an AXI4-Lite master for software and a flash on the pins.
*/
`default_nettype none

module fwp_ctrl #(
  parameter int AW = 20, // flash address width
  parameter int PULSE_NS = 10000 // protect / unprotect write pulse
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] s_awaddr, // axi write address
  input wire logic s_awvalid, // axi write address valid
  output logic s_awready, // axi write address ready
  input wire logic [31:0] s_wdata, // axi write data
  input wire logic [3:0] s_wstrb, // axi byte strobes
  input wire logic s_wvalid, // axi write data valid
  output logic s_wready, // axi write data ready
  output logic [1:0] s_bresp, // axi write response
  output logic s_bvalid, // axi write response valid
  input wire logic s_bready, // axi write response ready
  input wire logic [7:0] s_araddr, // axi read address
  input wire logic s_arvalid, // axi read address valid
  output logic s_arready, // axi read address ready
  output logic [31:0] s_rdata, // axi read data
  output logic [1:0] s_rresp, // axi read response
  output logic s_rvalid, // axi read valid
  input wire logic s_rready, // axi read ready
  output logic ce_b, // flash chip enable, low active
  output logic oe_b, // flash output enable, low active
  output logic we_b, // flash write enable, low active
  output logic [AW-1:0] addr, // flash address
  input wire logic [7:0] dq_in, // flash data pins in
  output logic [7:0] dq_out, // flash data drive value
  output logic dq_oe_b, // data drive enable, low drives
  output logic hv_addr_nine, // high voltage on address bit nine
  output logic hv_oe, // high voltage on output enable
  output logic hv_reset // high voltage on reset pin
);

  localparam int PULSE_CYC = (PULSE_NS + fwp_pkg::CLK_NS - 1) /
                             fwp_pkg::CLK_NS;

  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] flash_addr;
  logic [7:0] wr_data, rd_data;
  logic tmp_unprot, reject, toggling, first_high, tog_prev;
  fwp_pkg::fwp_op_t op;
  fwp_pkg::fwp_state_t state;
  logic [1:0] step;
  logic [15:0] cnt;
  logic [7:0] dq_s;

  fwp_sync #(.W(8)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din(dq_in),
    .dout(dq_s)
  );

  // register write decode
  wire do_wr = aw_full && w_full && !s_bvalid;
  wire hit_ctrl = aw_addr == fwp_pkg::REG_CTRL;
  wire hit_mode = aw_addr == fwp_pkg::REG_MODE;
  wire hit_addr = aw_addr == fwp_pkg::REG_ADDR;
  wire hit_wdat = aw_addr == fwp_pkg::REG_WDATA;
  wire wr_mapped = hit_ctrl || hit_mode || hit_addr || hit_wdat ||
                   aw_addr == fwp_pkg::REG_RDATA ||
                   aw_addr == fwp_pkg::REG_STATUS;
  wire busy = state != fwp_pkg::FWP_IDLE;
  // a start while busy is dropped, so a sequence is never cut short
  wire start = do_wr && hit_ctrl && w_strb[1] &&
               w_data[fwp_pkg::CTRL_GO_BIT] && !busy;

  // read mux
  wire [31:0] status = {28'h0000000, first_high, toggling, reject, busy};
  wire ar_mapped;
  wire [31:0] rd_mux;
  assign ar_mapped = s_araddr == fwp_pkg::REG_CTRL ||
                     s_araddr == fwp_pkg::REG_MODE ||
                     s_araddr == fwp_pkg::REG_ADDR ||
                     s_araddr == fwp_pkg::REG_WDATA ||
                     s_araddr == fwp_pkg::REG_RDATA ||
                     s_araddr == fwp_pkg::REG_STATUS;
  assign rd_mux = (s_araddr == fwp_pkg::REG_CTRL) ? {29'h0, op} :
                  (s_araddr == fwp_pkg::REG_MODE) ? {31'h0, tmp_unprot} :
                  (s_araddr == fwp_pkg::REG_ADDR) ? flash_addr :
                  (s_araddr == fwp_pkg::REG_WDATA) ? {24'h0, wr_data} :
                  (s_araddr == fwp_pkg::REG_RDATA) ? {24'h0, rd_data} :
                  (s_araddr == fwp_pkg::REG_STATUS) ? status : 32'h0;

  // axi write channel: address and data taken in either order
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= fwp_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_full <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_mapped ? fwp_pkg::RESP_OKAY : fwp_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // axi read channel, one cycle latency
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= fwp_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_mux;
      s_rresp <= ar_mapped ? fwp_pkg::RESP_OKAY : fwp_pkg::RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // software-written configuration
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      op <= fwp_pkg::FWP_OP_READ;
      tmp_unprot <= 1'b0;
      flash_addr <= fwp_pkg::RST_ADDR;
      wr_data <= fwp_pkg::RST_WDATA;
    end else if (do_wr && !busy) begin
      if (hit_ctrl && w_strb[0])
        op <= fwp_pkg::fwp_op_t'(w_data[2:0]);
      if (hit_mode && w_strb[0])
        tmp_unprot <= w_data[fwp_pkg::MODE_TMP_UNPROT_BIT];
      if (hit_addr)
        flash_addr <= w_data;
      if (hit_wdat && w_strb[0])
        wr_data <= w_data[7:0];
    end
  end

  // phase decode from op and step
  wire op_hv = op == fwp_pkg::FWP_OP_PROTECT ||
               op == fwp_pkg::FWP_OP_VERIFY ||
               op == fwp_pkg::FWP_OP_UNPROT;
  wire ph_write = op == fwp_pkg::FWP_OP_WRITE ||
                  op == fwp_pkg::FWP_OP_PROTECT ||
                  op == fwp_pkg::FWP_OP_UNPROT ||
                  (op == fwp_pkg::FWP_OP_ERASE_ADD && step == 2'd1);
  wire [1:0] last_step = (op == fwp_pkg::FWP_OP_TOGGLE) ? 2'd1 :
                         (op == fwp_pkg::FWP_OP_ERASE_ADD) ? 2'd2 : 2'd0;
  // reads wait out the synchroniser before sampling
  wire [15:0] strobe_len = (op_hv && ph_write) ? 16'(PULSE_CYC) :
                           ph_write ? 16'(fwp_pkg::STROBE_CYC) :
                           16'(fwp_pkg::STROBE_CYC + fwp_pkg::SYNC_CYC);
  // verify forces bit one high, bits zero and six low; unprotect sets six
  wire is_ver = op == fwp_pkg::FWP_OP_VERIFY;
  wire is_unp = op == fwp_pkg::FWP_OP_UNPROT;
  wire [AW-1:0] base = flash_addr[AW-1:0];
  wire [AW-1:0] next_addr = {base[AW-1:7], is_unp | (base[6] & ~is_ver),
                             base[5:2], is_ver | base[1],
                             base[0] & ~is_ver};
  wire cnt_zero = cnt == 16'h0000;
  wire capture = state == fwp_pkg::FWP_STROBE && cnt_zero && !ph_write;

  // pin sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= fwp_pkg::FWP_IDLE;
      step <= 2'd0;
      cnt <= 16'h0000;
      ce_b <= 1'b1;
      oe_b <= 1'b1;
      we_b <= 1'b1;
      addr <= '0;
      dq_out <= 8'h00;
      dq_oe_b <= 1'b1;
      hv_addr_nine <= 1'b0;
      hv_oe <= 1'b0;
    end else begin
      case (state)
        fwp_pkg::FWP_IDLE: if (start) begin
          state <= fwp_pkg::FWP_SETUP;
          step <= 2'd0;
          cnt <= 16'(fwp_pkg::SETUP_CYC); // pins lead the strobe edge
        end
        fwp_pkg::FWP_SETUP: begin
          addr <= next_addr;
          ce_b <= 1'b0;
          hv_addr_nine <= op_hv;
          hv_oe <= op == fwp_pkg::FWP_OP_PROTECT || is_unp;
          dq_out <= wr_data;
          dq_oe_b <= ~ph_write;
          if (cnt_zero) begin
            state <= fwp_pkg::FWP_STROBE;
            cnt <= strobe_len - 16'h0001;
            we_b <= ~ph_write;
            oe_b <= ph_write;
          end else
            cnt <= cnt - 16'h0001;
        end
        fwp_pkg::FWP_STROBE: if (cnt_zero) begin
          state <= fwp_pkg::FWP_HOLD;
          cnt <= 16'(fwp_pkg::HOLD_CYC - 1);
          we_b <= 1'b1;
          oe_b <= 1'b1;
        end else
          cnt <= cnt - 16'h0001;
        fwp_pkg::FWP_HOLD: if (cnt_zero) begin
          ce_b <= 1'b1;
          dq_oe_b <= 1'b1;
          if (step == last_step) begin
            state <= fwp_pkg::FWP_IDLE;
            hv_addr_nine <= 1'b0;
            hv_oe <= 1'b0;
          end else begin
            state <= fwp_pkg::FWP_SETUP;
            step <= step + 2'd1;
            cnt <= 16'(fwp_pkg::SETUP_CYC);
          end
        end else
          cnt <= cnt - 16'h0001;
        default: state <= fwp_pkg::FWP_IDLE;
      endcase
    end
  end

  // read capture and status; protecting all sectors before an
  // unprotect is left to software, which sees only the outcome
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
      reject <= 1'b0;
      toggling <= 1'b0;
      first_high <= 1'b0;
      tog_prev <= 1'b0;
      hv_reset <= 1'b0;
    end else begin
      hv_reset <= tmp_unprot;
      if (capture) begin
        rd_data <= dq_s;
        tog_prev <= dq_s[fwp_pkg::DQ_TOGGLE_BIT];
        if (op == fwp_pkg::FWP_OP_TOGGLE && step == 2'd1)
          toggling <= dq_s[fwp_pkg::DQ_TOGGLE_BIT] != tog_prev;
        if (op == fwp_pkg::FWP_OP_ERASE_ADD && step == 2'd0)
          first_high <= dq_s[fwp_pkg::DQ_WINDOW_BIT];
        if (op == fwp_pkg::FWP_OP_ERASE_ADD && step == 2'd2)
          reject <= dq_s[fwp_pkg::DQ_WINDOW_BIT];
      end
    end
  end

  sequence s_we_low2;
    !we_b [*2];
  endsequence

  sequence s_rd_strobe;
    !oe_b && !ce_b && we_b;
  endsequence

  a_write_levels: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !we_b |-> !ce_b && oe_b && !dq_oe_b)
    else $error("write strobe with wrong enable levels");
  a_no_drive_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !oe_b |-> dq_oe_b && we_b)
    else $error("data driven during a read strobe");
  a_we_min_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(we_b) |-> s_we_low2)
    else $error("write pulse shorter than two cycles");
  a_protect_hv: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!we_b && op == fwp_pkg::FWP_OP_PROTECT) |->
      hv_addr_nine && hv_oe)
    else $error("protect pulse without high voltage");
  a_verify_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_rd_strobe and is_ver) |->
      hv_addr_nine && addr[1] && !addr[0] && !addr[6] && !hv_oe)
    else $error("verify read with wrong pin levels");
  a_unprot_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!we_b && is_unp) |-> hv_oe && hv_addr_nine && !ce_b && addr[6])
    else $error("unprotect pulse with wrong pin levels");
  a_tmp_unprot: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(tmp_unprot) |=> hv_reset == $past(tmp_unprot))
    else $error("reset high voltage does not follow mode");
  a_reject_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (capture && op == fwp_pkg::FWP_OP_ERASE_ADD && step == 2'd2)
      |=> reject == $past(dq_s[fwp_pkg::DQ_WINDOW_BIT]))
    else $error("reject flag not from second window check");
  a_hv_idle_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == fwp_pkg::FWP_IDLE && $past(state) == fwp_pkg::FWP_HOLD)
      |-> !hv_addr_nine && !hv_oe && ce_b)
    else $error("high voltage left on after a sequence");

endmodule

`default_nettype wire

// File: testbench/fwp_flash_model.sv
/*
  Behavioural parallel flash for the controller bench: array, sector
  protection, erase window and toggle status, separate qualifiers.
  Assumes strobes from the controller and a resolved data bus input.
*/
`default_nettype none

module fwp_flash_model #(
  parameter logic [7:0] ID_CODE = 8'hC3 // arbitrary identity value
) (
  input wire logic ce_b, // chip enable, low active
  input wire logic oe_b, // output enable, low active
  input wire logic we_b, // write enable, low active
  input wire logic [19:0] addr, // address pins
  input wire logic [7:0] dq_bus, // resolved data bus
  input wire logic hv_addr_nine, // high voltage qualifier, address nine
  input wire logic hv_oe, // high voltage qualifier, output enable
  input wire logic hv_reset, // high voltage qualifier, reset pin
  output logic [7:0] dq // value the flash puts on the bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [15:0] prot;
  logic busy;
  logic tog;
  int rcnt;
  logic [7:0] last;
  logic [7:0] val;
  realtime t_fall;
  realtime t_addr;
  logic dozing;
  wire rd = !ce_b && !oe_b;
  wire [3:0] sec = addr[19:16];
  wire win = rcnt >= 3; // window closes after three status reads

  // power-up lands in read mode with a known array pattern
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
    prot = 16'h0000;
    busy = 1'b0;
    tog = 1'b0;
    rcnt = 0;
    last = 8'h00;
    t_fall = 0;
    t_addr = 0;
  end

  // verify, status or array data
  always_comb begin
    if (hv_addr_nine) begin
      val = addr[1] ? {7'h00, prot[sec]} : ID_CODE;
    end else if (busy) begin
      val = {1'b0, tog, 2'b00, win, 3'b000};
    end else begin
      val = mem[addr[7:0]];
    end
  end

  // a released bus never shows the last value
  assign dq = rd ? val : ~last;

  // each read cycle flips the toggle bit while erasing
  always @(posedge oe_b) begin
    if (!ce_b) begin
      last = val;
      if (busy) begin
        tog = ~tog;
        rcnt = rcnt + 1;
      end
    end
  end

  always @(negedge we_b) begin
    t_fall = $realtime;
  end

  // a still address past access time plus 30ns lets the part doze
  always @(addr) begin
    t_addr = $realtime;
  end
  always #5 begin
    dozing = ($realtime - t_addr) >= (fwp_pkg::ACCESS_NS + 30);
  end

  // writes need ce low, oe high and a pulse past the glitch filter
  always @(posedge we_b) begin
    if (!ce_b && oe_b && ($realtime - t_fall) >= 5.0) begin
      if (hv_addr_nine && hv_oe) begin
        if (addr[6]) begin
          prot = 16'h0000;
        end else begin
          prot[sec] = 1'b1;
        end
      end else if (busy) begin
        busy = busy; // added sectors join silently
      end else if (dq_bus == 8'h30) begin
        busy = 1'b1;
        rcnt = 0;
      end else if (!prot[sec] || hv_reset) begin
        mem[addr[7:0]] = dq_bus;
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
/*
  Self-checking bench for the flash protection controller.
  Assumes the flash model on the pins and an AXI4-Lite master here.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic s_awvalid = 1'b0;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic [3:0] s_wstrb = 4'hF;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic [7:0] s_araddr = 8'h00;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic ce_b, oe_b, we_b, dq_oe_b, hv_addr_nine, hv_oe, hv_reset;
  logic [19:0] addr;
  logic [7:0] dq_out, dq_flash;
  wire [7:0] dq_bus = !dq_oe_b ? dq_out : dq_flash; // controller wins
  int failures = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  always #10 clk_sys = ~clk_sys;

  fwp_ctrl #(.AW(20), .PULSE_NS(100)) i_dut (
    .clk_sys, .rst_b, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .ce_b, .oe_b, .we_b, .addr, .dq_in(dq_bus), .dq_out,
    .dq_oe_b, .hv_addr_nine, .hv_oe, .hv_reset
  );

  fwp_flash_model i_flash (
    .ce_b, .oe_b, .we_b, .addr, .dq_bus, .hv_addr_nine, .hv_oe, .hv_reset,
    .dq(dq_flash)
  );

  task automatic give_verdict;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stall;
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict;
  endtask

  // both write channels offered together, each dropped on its handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    bit aw, w, b;
    int n;
    aw = 1;
    w = 1;
    b = 0;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!b) begin
      @(posedge clk_sys);
      n++;
      if (aw && s_awready) begin
        aw = 0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready) begin
        w = 0;
        s_wvalid <= 1'b0;
      end
      if (s_bvalid) begin
        b = 1;
        chk({30'h0, s_bresp}, {30'h0, er});
      end
      if (n > 100) stall;
    end
    s_bready <= 1'b0;
    // one idle edge, so the next call never re-raises bready at once
    @(posedge clk_sys);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit ar, got;
    int n;
    ar = 1;
    got = 0;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!got) begin
      @(posedge clk_sys);
      n++;
      if (ar && s_arready) begin
        ar = 0;
        s_arvalid <= 1'b0;
      end
      if (s_rvalid) begin
        got = 1;
        d = s_rdata;
        r = s_rresp;
      end
      if (n > 100) stall;
    end
    s_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // load address and data, start an op, wait out busy, fetch the byte
  task automatic op_at(input logic [19:0] a, input logic [7:0] d,
                       input fwp_pkg::fwp_op_t op);
    logic [31:0] st;
    int n;
    st = 32'h1;
    n = 0;
    axi_wr(fwp_pkg::REG_ADDR, {12'h000, a}, fwp_pkg::RESP_OKAY);
    axi_wr(fwp_pkg::REG_WDATA, {24'h00_0000, d}, fwp_pkg::RESP_OKAY);
    axi_wr(fwp_pkg::REG_CTRL, {29'h0, op} | 32'h100, fwp_pkg::RESP_OKAY);
    while (st[fwp_pkg::ST_BUSY_BIT] !== 1'b0) begin
      axi_rd(fwp_pkg::REG_STATUS, st, rs);
      n++;
      if (n > 400) stall;
    end
    axi_rd(fwp_pkg::REG_RDATA, rd, rs);
  endtask

  // every write strobe must see the legal strobe combination
  always @(negedge we_b) begin
    chk({31'h0, oe_b}, 32'h1);
    chk({31'h0, ce_b}, 32'h0);
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    axi_rd(fwp_pkg::REG_STATUS, rd, rs);
    chk(rd, 32'h0);
    // unmapped place answers with an error and no data
    axi_rd(8'h18, rd, rs);
    chk({30'h0, rs}, {30'h0, fwp_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    axi_wr(8'h18, 32'h0, fwp_pkg::RESP_SLVERR);
    op_at(20'h00005, 8'h00, fwp_pkg::FWP_OP_READ);
    chk(rd, 32'h05);
    chk({31'h0, i_flash.dozing}, 32'h1);
    // protect one sector, verify it and a neighbour
    op_at(20'h10000, 8'h00, fwp_pkg::FWP_OP_PROTECT);
    op_at(20'h10000, 8'h00, fwp_pkg::FWP_OP_VERIFY);
    chk(rd, 32'h01);
    op_at(20'h20000, 8'h00, fwp_pkg::FWP_OP_VERIFY);
    chk(rd, 32'h00);
    op_at(20'h10004, 8'h3C, fwp_pkg::FWP_OP_WRITE);
    op_at(20'h10004, 8'h00, fwp_pkg::FWP_OP_READ);
    chk(rd, 32'h04);
    // temporary unprotect lets the write through, removal locks again
    axi_wr(fwp_pkg::REG_MODE, 32'h1, fwp_pkg::RESP_OKAY);
    axi_rd(fwp_pkg::REG_MODE, rd, rs);
    chk(rd, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, hv_reset}, 32'h1);
    op_at(20'h10004, 8'h3C, fwp_pkg::FWP_OP_WRITE);
    op_at(20'h10004, 8'h00, fwp_pkg::FWP_OP_READ);
    chk(rd, 32'h3C);
    axi_wr(fwp_pkg::REG_MODE, 32'h0, fwp_pkg::RESP_OKAY);
    op_at(20'h10004, 8'h77, fwp_pkg::FWP_OP_WRITE);
    op_at(20'h10004, 8'h00, fwp_pkg::FWP_OP_READ);
    chk(rd, 32'h3C);
    // every sector protected first, then the whole chip unprotected
    for (int s = 0; s < 16; s++) begin
      op_at({s[3:0], 16'h0000}, 8'h00, fwp_pkg::FWP_OP_PROTECT);
    end
    op_at(20'h20000, 8'h00, fwp_pkg::FWP_OP_VERIFY);
    chk(rd, 32'h01);
    op_at(20'h00000, 8'h00, fwp_pkg::FWP_OP_UNPROT);
    op_at(20'h10000, 8'h00, fwp_pkg::FWP_OP_VERIFY);
    chk(rd, 32'h00);
    op_at(20'h20000, 8'h00, fwp_pkg::FWP_OP_VERIFY);
    chk(rd, 32'h00);
    // first erase opens the window, later add finds it shut
    op_at(20'h00000, 8'h30, fwp_pkg::FWP_OP_ERASE_ADD);
    axi_rd(fwp_pkg::REG_STATUS, rd, rs);
    chk({31'h0, rd[fwp_pkg::ST_FIRST_HIGH_BIT]}, 32'h0);
    chk({31'h0, rd[fwp_pkg::ST_REJECT_BIT]}, 32'h0);
    op_at(20'h00000, 8'h00, fwp_pkg::FWP_OP_TOGGLE);
    axi_rd(fwp_pkg::REG_STATUS, rd, rs);
    chk({31'h0, rd[fwp_pkg::ST_TOGGLE_BIT]}, 32'h1);
    op_at(20'h00000, 8'h30, fwp_pkg::FWP_OP_ERASE_ADD);
    axi_rd(fwp_pkg::REG_STATUS, rd, rs);
    chk({31'h0, rd[fwp_pkg::ST_FIRST_HIGH_BIT]}, 32'h1);
    chk({31'h0, rd[fwp_pkg::ST_REJECT_BIT]}, 32'h1);
    give_verdict;
  end
endmodule

`default_nettype wire
